/* File: plc_demod_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ========
// demodulator stand-in; data fields except sym_header are inverted after their strobe
module plc_demod_model (
  input wire logic clk,
  output logic preamble_det,
  output logic rx_start,
  output logic [15:0] corr_level,
  output plc_stats_pkg::symbol_stat_t sym_stat,
  output plc_stats_pkg::carrier_evm_t carrier,
  output logic sym_done,
  output logic sym_header,
  output logic msg_end,
  output plc_stats_pkg::beacon_byte_t beacon
);
  initial
  begin
    preamble_det = 1'b0;
    rx_start = 1'b0;
    corr_level = 16'h0000;
    sym_stat = '0;
    carrier = '0;
    sym_done = 1'b0;
    sym_header = 1'b0;
    msg_end = 1'b0;
    beacon = '0;
  end
  task automatic preamble;
    @(posedge clk);
    preamble_det <= 1'b1;
    @(posedge clk);
    preamble_det <= 1'b0;
  endtask
  task automatic frame_start(input logic [15:0] lvl);
    @(posedge clk);
    rx_start <= 1'b1;
    corr_level <= lvl;
    @(posedge clk);
    rx_start <= 1'b0;
    corr_level <= ~lvl;
  endtask
  task automatic end_msg;
    @(posedge clk);
    msg_end <= 1'b1;
    @(posedge clk);
    msg_end <= 1'b0;
  endtask
  task automatic symbol(input logic [7:0] r, input logic [7:0] c, input logic hdr, input logic [2:0][15:0] ev);
    @(posedge clk);
    sym_stat <= {1'b1, r, c};
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      sym_stat <= {1'b0, ~r, ~c};
      carrier <= {1'b1, hdr, ev[k]};
    end
    // close the symbol only after its last carrier
    @(posedge clk);
    carrier <= {1'b0, ~hdr, ~ev[2]};
    sym_done <= 1'b1;
    sym_header <= hdr;
    @(posedge clk);
    sym_done <= 1'b0;
  endtask
  task automatic send_beacon(input logic [3:0][7:0] b);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      beacon <= {1'b1, b[k], k == 3};
    end
    @(posedge clk);
    beacon <= {1'b0, ~b[3], 1'b0};
  endtask
endmodule // plc_demod_model
`default_nettype wire

/* File: plc_rx_time_quality_stats.sv */
// Functional notes
// - 20-bit free-running time base, 10us unit
// - time base steps every 10us, wraps
// - preamble arrival captures time base value
// - timestamp left-aligned, low 12 bits zero
// - time base read as four left-aligned bytes
// - software writes to timers are ignored
// - chirp correlation level loaded at reception start
// - min, average, max signal strength per message
// - strength and ratio in quarter dB steps
// - min, average, max interference ratio per message
// - ratio measured against stored beacon table
// - load mode diverts beacon into the table
// - table load takes one cycle per byte
// - header peak error vector magnitude kept
// - payload peak error vector magnitude kept
// - magnitude format: 15:9 integer, 8:0 fraction
// - per-symbol sum of carrier magnitudes
// - header sum peak, 20 bits left-aligned
// - config bit switches load mode on and off
// - armed transmission starts when time base matches
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module plc_rx_time_quality_stats (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic preamble_det,
  input wire logic rx_start,
  input wire logic [15:0] corr_level,
  input wire plc_stats_pkg::symbol_stat_t sym_stat,
  input wire plc_stats_pkg::carrier_evm_t carrier,
  input wire logic sym_done,
  input wire logic sym_header,
  input wire logic msg_end,
  input wire plc_stats_pkg::beacon_byte_t beacon,
  output plc_stats_pkg::beacon_byte_t line_byte,
  input wire logic [5:0] ref_rd_addr,
  output logic [7:0] ref_rd_data,
  output logic reference_load_mode,
  output logic tx_start
);

  // ==========================================================
  // time base
  logic [8:0] prescale_ff;
  logic tick_ff;
  logic [19:0] tb_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prescale_ff <= 9'h000;
      tick_ff <= 1'b0;
    end
    else if (prescale_ff == plc_stats_pkg::TICK_CYCLES - 9'h001)
    begin
      prescale_ff <= 9'h000;
      tick_ff <= 1'b1;
    end
    else
    begin
      prescale_ff <= prescale_ff + 9'h001;
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tb_ff <= 20'h0_0000;
    else if (tick_ff)
      tb_ff <= (tb_ff == plc_stats_pkg::TB_MAX) ? 20'h0_0000 : tb_ff + 20'h0_0001;
  end

  // ==========================================================
  // arrival stamp and correlation level
  logic [19:0] frame_ff;
  logic [15:0] corr_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
      frame_ff <= 20'h0_0000;
    else if (preamble_det)
      frame_ff <= tb_ff;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      corr_ff <= 16'h0000;
    else if (rx_start)
      corr_ff <= corr_level;
  end

  // ==========================================================
  // per-symbol strength and ratio, quarter dB codes pass unchanged
  logic [7:0] rx_strength_minimum_w_ff, rx_strength_maximum_w_ff, interference_ratio_minimum_w_ff, interference_ratio_maximum_w_ff;
  logic [15:0] rssi_sum_w_ff, cinr_sum_w_ff;
  logic [7:0] sym_cnt_w_ff;

  always_ff @(posedge clk)
  begin
    if (rst || msg_end)
    begin
      rx_strength_minimum_w_ff <= plc_stats_pkg::STAT_MIN_RESET;
      interference_ratio_minimum_w_ff <= plc_stats_pkg::STAT_MIN_RESET;
      rx_strength_maximum_w_ff <= plc_stats_pkg::STAT_ZERO_RESET;
      interference_ratio_maximum_w_ff <= plc_stats_pkg::STAT_ZERO_RESET;
      rssi_sum_w_ff <= 16'h0000;
      cinr_sum_w_ff <= 16'h0000;
      sym_cnt_w_ff <= 8'h00;
    end
    else if (sym_stat.valid && sym_cnt_w_ff != 8'hFF)
    begin
      // count saturates at 255 symbols so sums never overflow 16 bits
      if (sym_stat.rssi < rx_strength_minimum_w_ff)
        rx_strength_minimum_w_ff <= sym_stat.rssi;
      if (sym_stat.rssi > rx_strength_maximum_w_ff)
        rx_strength_maximum_w_ff <= sym_stat.rssi;
      if (sym_stat.cinr < interference_ratio_minimum_w_ff)
        interference_ratio_minimum_w_ff <= sym_stat.cinr;
      if (sym_stat.cinr > interference_ratio_maximum_w_ff)
        interference_ratio_maximum_w_ff <= sym_stat.cinr;
      rssi_sum_w_ff <= rssi_sum_w_ff + {8'h00, sym_stat.rssi};
      cinr_sum_w_ff <= cinr_sum_w_ff + {8'h00, sym_stat.cinr};
      sym_cnt_w_ff <= sym_cnt_w_ff + 8'h01;
    end
  end

  // ==========================================================
  // error vector magnitude tracking
  logic [15:0] hdr_peak_w_ff, pay_peak_w_ff;
  logic [19:0] sym_sum_ff, hdr_sum_peak_w_ff;
  logic [20:0] sum_ext;

  assign sum_ext = {1'b0, sym_sum_ff} + {5'h00, carrier.evm};

  always_ff @(posedge clk)
  begin
    if (rst || sym_done)
      sym_sum_ff <= 20'h0_0000;
    else if (carrier.valid)
      sym_sum_ff <= sum_ext[20] ? plc_stats_pkg::SUM_SAT : sum_ext[19:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst || msg_end)
    begin
      hdr_peak_w_ff <= 16'h0000;
      pay_peak_w_ff <= 16'h0000;
    end
    else if (carrier.valid)
    begin
      // 16-bit code compared whole: integer 15:9 and fraction 8:0 order alike
      if (carrier.header && carrier.evm > hdr_peak_w_ff)
        hdr_peak_w_ff <= carrier.evm;
      if (!carrier.header && carrier.evm > pay_peak_w_ff)
        pay_peak_w_ff <= carrier.evm;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || msg_end)
      hdr_sum_peak_w_ff <= 20'h0_0000;
    else if (sym_done && sym_header && sym_sum_ff > hdr_sum_peak_w_ff)
      hdr_sum_peak_w_ff <= sym_sum_ff;
  end

  // ==========================================================
  // published results, held until the next message ends
  logic [7:0] rx_strength_minimum_ff, rx_strength_maximum_ff, interference_ratio_minimum_ff, interference_ratio_maximum_ff;
  logic [15:0] hdr_peak_ff, pay_peak_ff;
  logic [19:0] hdr_sum_peak_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_strength_minimum_ff <= plc_stats_pkg::STAT_MIN_RESET;
      interference_ratio_minimum_ff <= plc_stats_pkg::STAT_MIN_RESET;
      rx_strength_maximum_ff <= plc_stats_pkg::STAT_ZERO_RESET;
      interference_ratio_maximum_ff <= plc_stats_pkg::STAT_ZERO_RESET;
      hdr_peak_ff <= 16'h0000;
      pay_peak_ff <= 16'h0000;
      hdr_sum_peak_ff <= 20'h0_0000;
    end
    else if (msg_end)
    begin
      rx_strength_minimum_ff <= rx_strength_minimum_w_ff;
      rx_strength_maximum_ff <= rx_strength_maximum_w_ff;
      interference_ratio_minimum_ff <= interference_ratio_minimum_w_ff;
      interference_ratio_maximum_ff <= interference_ratio_maximum_w_ff;
      hdr_peak_ff <= hdr_peak_w_ff;
      pay_peak_ff <= pay_peak_w_ff;
      hdr_sum_peak_ff <= hdr_sum_peak_w_ff;
    end
  end

  // ==========================================================
  // averages by repeated subtraction; a slow divider is cheap and
  // its at most 256 cycles are far shorter than any message
  plc_stats_pkg::avg_state_t avg_state_ff;
  logic [15:0] rssi_rem_ff, cinr_rem_ff;
  logic [7:0] div_cnt_ff, rssi_quo_ff, cinr_quo_ff, rx_strength_average_ff, interference_ratio_average_ff;
  logic rssi_more, cinr_more;

  assign rssi_more = (div_cnt_ff != 8'h00) && (rssi_rem_ff >= {8'h00, div_cnt_ff}) && (rssi_quo_ff != 8'hFF);
  assign cinr_more = (div_cnt_ff != 8'h00) && (cinr_rem_ff >= {8'h00, div_cnt_ff}) && (cinr_quo_ff != 8'hFF);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avg_state_ff <= plc_stats_pkg::ST_COLLECT;
      rssi_rem_ff <= 16'h0000;
      cinr_rem_ff <= 16'h0000;
      div_cnt_ff <= 8'h00;
      rssi_quo_ff <= 8'h00;
      cinr_quo_ff <= 8'h00;
      rx_strength_average_ff <= plc_stats_pkg::STAT_ZERO_RESET;
      interference_ratio_average_ff <= plc_stats_pkg::STAT_ZERO_RESET;
    end
    else
    begin
      case (avg_state_ff)
        plc_stats_pkg::ST_COLLECT:
        begin
          if (msg_end)
          begin
            rssi_rem_ff <= rssi_sum_w_ff;
            cinr_rem_ff <= cinr_sum_w_ff;
            div_cnt_ff <= sym_cnt_w_ff;
            rssi_quo_ff <= 8'h00;
            cinr_quo_ff <= 8'h00;
            avg_state_ff <= plc_stats_pkg::ST_DIVIDE;
          end
        end
        plc_stats_pkg::ST_DIVIDE:
        begin
          if (rssi_more)
          begin
            rssi_rem_ff <= rssi_rem_ff - {8'h00, div_cnt_ff};
            rssi_quo_ff <= rssi_quo_ff + 8'h01;
          end
          if (cinr_more)
          begin
            cinr_rem_ff <= cinr_rem_ff - {8'h00, div_cnt_ff};
            cinr_quo_ff <= cinr_quo_ff + 8'h01;
          end
          if (!rssi_more && !cinr_more)
            avg_state_ff <= plc_stats_pkg::ST_PUBLISH;
        end
        plc_stats_pkg::ST_PUBLISH:
        begin
          rx_strength_average_ff <= rssi_quo_ff;
          interference_ratio_average_ff <= cinr_quo_ff;
          avg_state_ff <= plc_stats_pkg::ST_COLLECT;
        end
        default:
          avg_state_ff <= plc_stats_pkg::ST_COLLECT;
      endcase
    end
  end

  // ==========================================================
  // register writes and transmit scheduling
  logic access;
  logic wr_en;
  logic [15:0] idx;
  logic ref_mode_ff;
  logic tx_order_ff, tx_started_ff, tx_start_ff;
  logic [19:0] tx_time_ff;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = access && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[17:2];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ref_mode_ff <= 1'b0;
      tx_order_ff <= plc_stats_pkg::TX_ORDER_RESET;
      tx_time_ff <= 20'h0_0000;
    end
    else if (wr_en)
    begin
      // timer and statistics indices have no write path here
      case (idx)
        plc_stats_pkg::IDX_CONFIG: ref_mode_ff <= wb_dat_i[plc_stats_pkg::CFG_REF_MODE_BIT];
        plc_stats_pkg::IDX_STATUS: tx_order_ff <= wb_dat_i[plc_stats_pkg::STATUS_TX_ORDER_BIT];
        plc_stats_pkg::IDX_TX_TIME0: tx_time_ff[19:12] <= wb_dat_i[7:0];
        plc_stats_pkg::IDX_TX_TIME1: tx_time_ff[11:4] <= wb_dat_i[7:0];
        plc_stats_pkg::IDX_TX_TIME2: tx_time_ff[3:0] <= wb_dat_i[7:4];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_started_ff <= 1'b0;
      tx_start_ff <= 1'b0;
    end
    else
    begin
      tx_start_ff <= 1'b0;
      // a status write re-arms; a match in the same cycle still wins
      if (wr_en && idx == plc_stats_pkg::IDX_STATUS)
        tx_started_ff <= 1'b0;
      if (!tx_order_ff && !tx_started_ff && tb_ff == tx_time_ff)
      begin
        tx_started_ff <= 1'b1;
        tx_start_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // beacon reference table
  logic [7:0] ref_table [plc_stats_pkg::REF_DEPTH];
  logic [5:0] ref_wr_addr_ff;
  logic [7:0] ref_rd_data_ff;
  plc_stats_pkg::beacon_byte_t line_ff;

  always_ff @(posedge clk)
  begin
    if (beacon.valid && ref_mode_ff)
      ref_table[ref_wr_addr_ff] <= beacon.data;
    ref_rd_data_ff <= ref_table[ref_rd_addr];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ref_wr_addr_ff <= 6'h00;
    else if (beacon.valid && ref_mode_ff)
      ref_wr_addr_ff <= beacon.last ? 6'h00 : ref_wr_addr_ff + 6'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      line_ff <= '0;
    else
    begin
      line_ff <= beacon;
      line_ff.valid <= beacon.valid && !ref_mode_ff;
    end
  end

  // ==========================================================
  // register reads; unmapped indices read zero and still ack
  logic [7:0] nxt_rd_byte;
  logic [31:0] rd_data_ff;
  logic ack_ff;

  always_comb
  begin
    nxt_rd_byte = 8'h00;
    case (idx)
      plc_stats_pkg::IDX_TX_TIME0: nxt_rd_byte = tx_time_ff[19:12];
      plc_stats_pkg::IDX_TX_TIME1: nxt_rd_byte = tx_time_ff[11:4];
      plc_stats_pkg::IDX_TX_TIME2: nxt_rd_byte = {tx_time_ff[3:0], 4'h0};
      plc_stats_pkg::IDX_STATUS: nxt_rd_byte = {5'h00, !tx_started_ff, 2'h0};
      plc_stats_pkg::IDX_FRAME0: nxt_rd_byte = frame_ff[19:12];
      plc_stats_pkg::IDX_FRAME0 + 16'h0001: nxt_rd_byte = frame_ff[11:4];
      plc_stats_pkg::IDX_FRAME0 + 16'h0002: nxt_rd_byte = {frame_ff[3:0], 4'h0};
      plc_stats_pkg::IDX_CORR0: nxt_rd_byte = corr_ff[15:8];
      plc_stats_pkg::IDX_CORR0 + 16'h0001: nxt_rd_byte = corr_ff[7:0];
      plc_stats_pkg::IDX_RX_STRENGTH_MINIMUM: nxt_rd_byte = rx_strength_minimum_ff;
      plc_stats_pkg::IDX_RX_STRENGTH_AVERAGE: nxt_rd_byte = rx_strength_average_ff;
      plc_stats_pkg::IDX_RX_STRENGTH_MAXIMUM: nxt_rd_byte = rx_strength_maximum_ff;
      plc_stats_pkg::IDX_INTERFERENCE_RATIO_MINIMUM: nxt_rd_byte = interference_ratio_minimum_ff;
      plc_stats_pkg::IDX_INTERFERENCE_RATIO_AVERAGE: nxt_rd_byte = interference_ratio_average_ff;
      plc_stats_pkg::IDX_INTERFERENCE_RATIO_MAXIMUM: nxt_rd_byte = interference_ratio_maximum_ff;
      plc_stats_pkg::IDX_HDR_PEAK0: nxt_rd_byte = hdr_peak_ff[15:8];
      plc_stats_pkg::IDX_HDR_PEAK0 + 16'h0001: nxt_rd_byte = hdr_peak_ff[7:0];
      plc_stats_pkg::IDX_PAY_PEAK0: nxt_rd_byte = pay_peak_ff[15:8];
      plc_stats_pkg::IDX_PAY_PEAK0 + 16'h0001: nxt_rd_byte = pay_peak_ff[7:0];
      plc_stats_pkg::IDX_HDR_SUM0: nxt_rd_byte = hdr_sum_peak_ff[19:12];
      plc_stats_pkg::IDX_HDR_SUM0 + 16'h0001: nxt_rd_byte = hdr_sum_peak_ff[11:4];
      plc_stats_pkg::IDX_HDR_SUM0 + 16'h0002: nxt_rd_byte = {hdr_sum_peak_ff[3:0], 4'h0};
      plc_stats_pkg::IDX_TB0: nxt_rd_byte = tb_ff[19:12];
      plc_stats_pkg::IDX_TB0 + 16'h0001: nxt_rd_byte = tb_ff[11:4];
      plc_stats_pkg::IDX_TB0 + 16'h0002: nxt_rd_byte = {tb_ff[3:0], 4'h0};
      plc_stats_pkg::IDX_CONFIG: nxt_rd_byte = {2'h0, ref_mode_ff, 5'h00};
      default: nxt_rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
      rd_data_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= access;
      if (access)
        rd_data_ff <= {24'h00_0000, nxt_rd_byte};
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_data_ff;
  assign line_byte = line_ff;
  assign ref_rd_data = ref_rd_data_ff;
  assign reference_load_mode = ref_mode_ff;
  assign tx_start = tx_start_ff;

endmodule // plc_rx_time_quality_stats

`default_nettype wire

/* File: plc_stats_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// ========
// port relations of the statistics bank
module plc_stats_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire plc_stats_pkg::beacon_byte_t beacon,
  input wire plc_stats_pkg::beacon_byte_t line_byte,
  input wire logic reference_load_mode,
  input wire logic tx_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_s(idx);
    req_s ##0 (!wb_we_i && wb_adr_i[17:2] == idx);
  endsequence
  ack_answer_a: assert property (req_s |=> wb_ack_o) else $error("request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  byte_lane_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper lanes set");
  stamp_pad_a: assert property (rd_s(plc_stats_pkg::IDX_FRAME0 + 16'h0003) |=> wb_dat_o == 32'h0000_0000)
    else $error("stamp pad byte not zero");
  stamp_nibble_a: assert property (rd_s(plc_stats_pkg::IDX_FRAME0 + 16'h0002) |=> wb_dat_o[3:0] == 4'h0)
    else $error("stamp low nibble not zero");
  base_pad_a: assert property (rd_s(plc_stats_pkg::IDX_TB0 + 16'h0003) |=> wb_dat_o == 32'h0000_0000)
    else $error("time base pad byte not zero");
  load_block_a: assert property ($past(reference_load_mode) |-> !line_byte.valid)
    else $error("beacon reached the line in load mode");
  line_copy_a: assert property ((beacon.valid && !reference_load_mode) ##1 !reference_load_mode
    |-> line_byte == $past(beacon)) else $error("beacon not passed to the line");
  tx_pulse_a: assert property (tx_start |=> !tx_start) else $error("start pulse too long");
  // no disable here: this one is about the reset itself
  reset_state_a: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !tx_start && !reference_load_mode
    && wb_dat_o == 32'h0000_0000) else $error("outputs not cleared by reset");
endmodule // plc_stats_checker
bind plc_rx_time_quality_stats plc_stats_checker u_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .beacon, .line_byte, .reference_load_mode, .tx_start);
`default_nettype wire

/* File: plc_stats_pkg.sv */
package plc_stats_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_PERIOD_NS = 10000;
  localparam logic [8:0] TICK_CYCLES = 9'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [19:0] TB_MAX = 20'hF_FFFF;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_TX_TIME0 = 16'hFE26;
  localparam logic [15:0] IDX_TX_TIME1 = 16'hFE27;
  localparam logic [15:0] IDX_TX_TIME2 = 16'hFE28;
  localparam logic [15:0] IDX_TX_TIME3 = 16'hFE29;
  localparam logic [15:0] IDX_STATUS = 16'hFE2A;
  localparam logic [15:0] IDX_FRAME0 = 16'hFE2D;
  localparam logic [15:0] IDX_CORR0 = 16'hFE31;
  localparam logic [15:0] IDX_RX_STRENGTH_MINIMUM = 16'hFE33;
  localparam logic [15:0] IDX_RX_STRENGTH_AVERAGE = 16'hFE34;
  localparam logic [15:0] IDX_RX_STRENGTH_MAXIMUM = 16'hFE35;
  localparam logic [15:0] IDX_INTERFERENCE_RATIO_MINIMUM = 16'hFE38;
  localparam logic [15:0] IDX_INTERFERENCE_RATIO_AVERAGE = 16'hFE39;
  localparam logic [15:0] IDX_INTERFERENCE_RATIO_MAXIMUM = 16'hFE3A;
  localparam logic [15:0] IDX_HDR_PEAK0 = 16'hFE3B;
  localparam logic [15:0] IDX_PAY_PEAK0 = 16'hFE3D;
  localparam logic [15:0] IDX_HDR_SUM0 = 16'hFE3F;
  localparam logic [15:0] IDX_TB0 = 16'hFE47;
  localparam logic [15:0] IDX_CONFIG = 16'hFE68;

  // ==========================================================
  // fields and reset values
  localparam int unsigned CFG_REF_MODE_BIT = 5;
  localparam int unsigned STATUS_TX_ORDER_BIT = 2;
  localparam logic TX_ORDER_RESET = 1'b1;
  localparam logic [7:0] STAT_MIN_RESET = 8'hFF;
  localparam logic [7:0] STAT_ZERO_RESET = 8'h00;
  localparam logic [19:0] SUM_SAT = 20'hF_FFFF;
  localparam int unsigned REF_DEPTH = 64;
  localparam int unsigned REF_AW = 6;

  // ==========================================================
  // records from the demodulator and divider states
  typedef struct packed {
    logic valid;
    logic [7:0] rssi;
    logic [7:0] cinr;
  } symbol_stat_t;

  typedef struct packed {
    logic valid;
    logic header;
    logic [15:0] evm;
  } carrier_evm_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } beacon_byte_t;

  typedef enum logic [1:0] {
    ST_COLLECT = 2'b00,
    ST_DIVIDE = 2'b01,
    ST_PUBLISH = 2'b10
  } avg_state_t;

endpackage

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rst, cyc, stb, we, ack, ref_mode, tx_start, preamble_det, rx_start, sym_done, sym_header, msg_end;
  logic [17:0] adr;
  logic [31:0] wdat, rdat;
  logic [5:0] ref_addr;
  logic [7:0] ref_data, last_rd;
  logic [15:0] corr_level;
  plc_stats_pkg::symbol_stat_t sym_stat;
  plc_stats_pkg::carrier_evm_t carrier;
  plc_stats_pkg::beacon_byte_t beacon, line_byte;
  logic [32:0] exp_q[$];
  logic [7:0] e[18];
  int num_errors = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int t_edge, t0;
  plc_rx_time_quality_stats u_plc_rx_time_quality_stats (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .preamble_det(preamble_det), .rx_start(rx_start), .corr_level(corr_level), .sym_stat(sym_stat),
    .carrier(carrier), .sym_done(sym_done), .sym_header(sym_header), .msg_end(msg_end), .beacon(beacon),
    .line_byte(line_byte), .ref_rd_addr(ref_addr), .ref_rd_data(ref_data), .reference_load_mode(ref_mode),
    .tx_start(tx_start));
  plc_demod_model u_dm (.clk(clk), .preamble_det(preamble_det), .rx_start(rx_start), .corr_level(corr_level),
    .sym_stat(sym_stat), .carrier(carrier), .sym_done(sym_done), .sym_header(sym_header), .msg_end(msg_end),
    .beacon(beacon));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc_cnt <= cyc_cnt + 1;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic finish_test;
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ========
  // bus master and read scoreboard
  always @(posedge clk)
    if (ack && !we && exp_q.size() > 0)
    begin
      if (exp_q[0][32])
        check("read data", rdat, exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [8:0] want);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    if (!w)
      exp_q.push_back({want[8], 24'h00_0000, want[7:0]});
    // no answer time is assumed; only the watchdog ends a hung access
    while (!ack) @(posedge clk);
    last_rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] want);
    bus(1'b0, idx, 8'h00, {1'b1, want});
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 9'h000);
  endtask
  function automatic logic [7:0] tbyte(input logic [19:0] v, input int k);
    logic [31:0] w;
    w = {v, 12'h000};
    return w[31 - 8 * k -: 8];
  endfunction
  task automatic check_stats;
    for (int k = 0; k < 18; k++) rd(plc_stats_pkg::IDX_CORR0 + 16'(k), e[k]);
  endtask
  // ========
  // main sequence
  initial
  begin : main
    logic [7:0] r, c, rmin, rmax, cmin, cmax;
    logic [15:0] hp, pp, corr;
    logic [19:0] hs, s20;
    logic [2:0][15:0] ev;
    logic [3:0][7:0] bk;
    int rsum, csum, n, tx;
    void'($urandom(55));
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 18'h0_0000;
    wdat = 32'h0000_0000;
    ref_addr = 6'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    e = '{default: 8'h00};
    e[2] = 8'hff;
    e[7] = 8'hff;
    for (int k = 0; k < 4; k++) rd(plc_stats_pkg::IDX_FRAME0 + 16'(k), 8'h00);
    check_stats;
    for (int k = 0; k < 4; k++) rd(plc_stats_pkg::IDX_TB0 + 16'(k), 8'h00);
    // lock onto the tick phase so later stamps are exact
    bus(1'b0, plc_stats_pkg::IDX_TB0 + 16'h0002, 8'h00, 9'h000);
    r = last_rd;
    for (int k = 0; k < 300 && last_rd == r; k++) bus(1'b0, plc_stats_pkg::IDX_TB0 + 16'h0002, 8'h00, 9'h000);
    t_edge = cyc_cnt;
    c = last_rd;
    bus(1'b0, plc_stats_pkg::IDX_TB0 + 16'h0001, 8'h00, 9'h000);
    t0 = int'({last_rd, c[7:4]});
    while (cyc_cnt < t_edge + 2200) @(posedge clk);
    u_dm.preamble;
    for (int k = 0; k < 4; k++) rd(plc_stats_pkg::IDX_FRAME0 + 16'(k), tbyte(20'(t0 + 5), k));
    for (int m = 0; m < 2; m++)
    begin
      corr = 16'($urandom);
      n = 3 + $urandom % 4;
      {rmin, cmin, rmax, cmax, rsum, csum, hp, pp, hs} = {8'hff, 8'hff, 132'h0};
      u_dm.frame_start(corr);
      for (int s = 0; s < n; s++)
      begin
        r = 8'($urandom);
        c = 8'($urandom);
        ev = 48'({$urandom, $urandom});
        rsum += r;
        csum += c;
        if (r < rmin) rmin = r;
        if (r > rmax) rmax = r;
        if (c < cmin) cmin = c;
        if (c > cmax) cmax = c;
        s20 = 20'(ev[0]) + 20'(ev[1]) + 20'(ev[2]);
        for (int j = 0; j < 3; j++)
          if (s < 2 && ev[j] > hp) hp = ev[j];
          else if (s >= 2 && ev[j] > pp) pp = ev[j];
        if (s < 2 && s20 > hs) hs = s20;
        u_dm.symbol(r, c, s < 2, ev);
      end
      u_dm.end_msg;
      repeat (300) @(posedge clk);
      {e[0], e[1], e[2], e[3], e[4]} = {corr, rmin, 8'(rsum / n), rmax};
      {e[7], e[8], e[9], e[10], e[11], e[12], e[13]} = {cmin, 8'(csum / n), cmax, hp, pp};
      for (int k = 0; k < 4; k++) e[14 + k] = tbyte(hs, k);
      check_stats;
      wr(plc_stats_pkg::IDX_RX_STRENGTH_MINIMUM, 8'h5a);
      wr(plc_stats_pkg::IDX_FRAME0, 8'h5a);
      wr(plc_stats_pkg::IDX_TB0, 8'h5a);
      check_stats;
    end
    rd(plc_stats_pkg::IDX_FRAME0, tbyte(20'(t0 + 5), 0));
    // table load: mode on, beacon diverted, mode off again
    wr(plc_stats_pkg::IDX_CONFIG, 8'h20);
    check("load mode", 32'(ref_mode), 32'h0000_0001);
    bk = 32'($urandom);
    u_dm.send_beacon(bk);
    for (int k = 0; k < 4; k++)
    begin
      ref_addr <= 6'(k);
      repeat (2) @(posedge clk);
      check("table byte", 32'(ref_data), 32'(bk[k]));
    end
    wr(plc_stats_pkg::IDX_CONFIG, 8'h00);
    check("load mode", 32'(ref_mode), 32'h0000_0000);
    u_dm.send_beacon(bk);
    // armed send three ticks ahead
    tx = t0 + (cyc_cnt - t_edge) / 400 + 3;
    for (int k = 0; k < 3; k++) wr(plc_stats_pkg::IDX_TX_TIME0 + 16'(k), tbyte(20'(tx), k));
    wr(plc_stats_pkg::IDX_STATUS, 8'h00);
    for (int k = 0; k < 2000 && !tx_start; k++) @(posedge clk);
    check("start tick", 32'(t0 + (cyc_cnt - t_edge + 200) / 400), 32'(tx));
    finish_test;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
